// file: dv/rbs_asserts.sv
// Port checker for the reset and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module rbs_asserts
    import rbs_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = 20
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reset_in_n,
    input wire logic        bus_width_strap_lo,
    input wire logic        watchdog_out_pin,
    input wire logic        cpu_reset,
    input wire logic [31:0] system_stack_pointer,
    input wire logic [2:0]  interrupt_mask_level,
    input wire logic [1:0]  register_bank_pointer,
    input wire logic [2:0]  clock_gear,
    input wire logic        port_input_mode,
    input wire logic        io_regs_init,
    input wire logic        bus_16bit,
    input wire logic [1:0]  bus_wait_states
);
    // ------------------------------------------------------------
    // Pin low run and time since leaving hold
    // ------------------------------------------------------------
    logic [3:0]  low_q;
    logic [3:0]  run_q;
    logic [31:0] rel_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_q <= 4'h0;
            run_q <= 4'h0;
            rel_q <= 32'h0;
        end else begin
            low_q <= reset_in_n ? 4'h0 : low_q + {3'h0, low_q != 4'hF};
            if (reset_in_n && low_q != 4'h0) begin
                run_q <= low_q;
            end
            rel_q <= io_regs_init ? 32'h0 : rel_q + {31'h0, rel_q != 32'hFFFF_FFFF};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_wdt_lo; io_regs_init |-> !watchdog_out_pin; endproperty
    a_wdt_lo: assert property (p_wdt_lo) else $error("watchdog high in hold");
    property p_wdt_hi; !io_regs_init && !$past(io_regs_init) |-> watchdog_out_pin; endproperty
    a_wdt_hi: assert property (p_wdt_hi) else $error("watchdog low after release");
    property p_gear; io_regs_init |-> clock_gear == GEAR_DIV16; endproperty
    a_gear: assert property (p_gear) else $error("gear not div16 in hold");
    property p_hold; io_regs_init |-> cpu_reset && port_input_mode; endproperty
    a_hold: assert property (p_hold) else $error("cpu or ports not held");
    property p_cpust;
        io_regs_init |-> system_stack_pointer == SP_RESET
            && interrupt_mask_level == MASK_RESET && register_bank_pointer == BANK_RESET;
    endproperty
    a_cpust: assert property (p_cpust) else $error("cpu state not reset");
    // Stale run is overwritten by any later short pulse
    property p_accept; $rose(io_regs_init) |-> low_q >= 4'hA || run_q >= 4'hA; endproperty
    a_accept: assert property (p_accept) else $error("short pulse accepted");
    property p_settle; !cpu_reset |-> rel_q >= STAB_CYCLES; endproperty
    a_settle: assert property (p_settle) else $error("cpu released early");
    property p_width;
        $fell(io_regs_init) |-> bus_16bit == $past(bus_width_strap_lo) && bus_wait_states == BOOT_WAITS;
    endproperty
    a_width: assert property (p_width) else $error("bus width not sampled");
endmodule // rbs_asserts
bind rbs_reset_boot_sequencer rbs_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
    .ref_clk, .rst, .reset_in_n, .bus_width_strap_lo, .watchdog_out_pin, .cpu_reset,
    .system_stack_pointer, .interrupt_mask_level, .register_bank_pointer, .clock_gear,
    .port_input_mode, .io_regs_init, .bus_16bit, .bus_wait_states
);
`default_nettype wire

// file: dv/rbs_board.sv
// Board model: reset pin source and boot vector memory
`timescale 1ns/1ps
`default_nettype none
module rbs_board (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        vec_rd_req,
    input  wire logic [23:0] vec_addr,
    input  wire logic [23:0] vec_word,
    input  wire logic [1:0]  dly,
    output var  logic        reset_in_n,
    output var  logic [7:0]  vec_rdata,
    output var  logic        vec_rd_ack
);
    logic [1:0] wt_q;
    initial reset_in_n = 1'b1;
    // Called just after a clock edge
    task automatic hold_low(input int n);
        reset_in_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        reset_in_n <= 1'b1;
    endtask
    // Data toggles outside the ack cycle so stale bytes never match
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wt_q       <= 2'h0;
            vec_rd_ack <= 1'b0;
            vec_rdata  <= 8'h00;
        end else begin
            vec_rd_ack <= 1'b0;
            vec_rdata  <= ~vec_rdata;
            if (vec_rd_req && !vec_rd_ack) begin
                wt_q <= wt_q + 2'h1;
                if (wt_q == dly) begin
                    wt_q       <= 2'h0;
                    vec_rd_ack <= 1'b1;
                    vec_rdata  <= vec_word[8*vec_addr[1:0] +: 8];
                end
            end
        end
    end
endmodule // rbs_board
`default_nettype wire

// file: dv/tb_reset_boot_sequencer.sv
// Self-checking bench for the reset and boot sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_reset_boot_sequencer
    import rbs_pkg::*;
;
    logic        ref_clk, rst, reset_in_n, bus_width_strap_lo, bus_width_strap_hi, factory_strap_a;
    logic        factory_strap_b, vec_rd_req, vec_rd_ack, cpu_start, bus_16bit, strap_fault;
    logic        factory_fault, psel, penable, pwrite, pready, pslverr;
    logic [23:0] vec_addr, program_counter, vec_word;
    logic [31:0] pwdata, prdata;
    logic [11:0] paddr;
    logic [7:0]  vec_rdata;
    logic [3:0]  pstrb;
    logic [1:0]  dly;
    logic [32:0] exp_r[$], exp_b[$];
    int          num_errors = 0, checked = 0;
    rbs_reset_boot_sequencer #(.STAB_CYCLES(20)) u_dut (
        .ref_clk, .rst, .reset_in_n, .bus_width_strap_lo, .bus_width_strap_hi, .factory_strap_a,
        .factory_strap_b, .watchdog_out_pin(), .vec_rd_req, .vec_addr, .vec_rdata, .vec_rd_ack,
        .cpu_reset(), .cpu_start, .program_counter, .system_stack_pointer(), .interrupt_mask_level(),
        .register_bank_pointer(), .clock_gear(), .port_input_mode(), .io_regs_init(), .bus_16bit,
        .bus_wait_states(), .strap_fault, .factory_fault, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr
    );
    rbs_board u_board (
        .ref_clk, .rst, .vec_rd_req, .vec_addr, .vec_word, .dly, .reset_in_n, .vec_rdata, .vec_rd_ack
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task cmp(input logic [32:0] got, input logic [32:0] want);
        checked++;
        if (got !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    task end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_r.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task note();
        exp_b.push_back({6'h0, vec_word, bus_width_strap_lo, bus_width_strap_hi, factory_strap_a | factory_strap_b});
    endtask
    task wait_start();
        for (int k = 0; k < 400 && cpu_start !== 1'b1; k++)
            @(posedge ref_clk);
        @(posedge ref_clk);
    endtask
    // Any start with no note queued is a mismatch
    always @(posedge ref_clk) begin
        if (!rst && pready === 1'b1 && !pwrite && exp_r.size() > 0)
            cmp({pslverr, prdata}, exp_r.pop_front());
        if (!rst && cpu_start === 1'b1)
            cmp({6'h0, program_counter, bus_16bit, strap_fault, factory_fault}, exp_b.size() > 0 ? exp_b.pop_front() : 'x);
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        pstrb = 4'hF;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_width_strap_lo, bus_width_strap_hi, factory_strap_a, factory_strap_b, dly} = '0;
        void'($urandom(32'h484D2EB8));
        vec_word = 24'($urandom);
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        note();
        wait_start();
        rd(OFS_GEAR, {30'h0, GEAR_DIV16});
        rd(OFS_SR, {27'h0, BANK_RESET, 1'b0, MASK_RESET});
        rd(OFS_SP, {1'b0, SP_RESET});
        rd(OFS_STATUS, 33'h33);
        rd(12'hFFC, 33'h1_0000_0000);
        apb(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_STATUS, 33'h13);
        u_board.hold_low(9);
        repeat (20) @(posedge ref_clk);
        rd(OFS_STATUS, 33'h13);
        $display("test basic done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_GEAR, {29'h0, 3'(i) ^ 3'h3});
            {bus_width_strap_lo, bus_width_strap_hi, factory_strap_a, factory_strap_b} <= {i[0], i == 3, i == 2, i == 3};
            dly <= 2'(i);
            vec_word <= 24'($urandom);
            @(posedge ref_clk);
            if (i == 1) begin
                u_board.hold_low(10);
                repeat (15) @(posedge ref_clk);
            end
            note();
            u_board.hold_low(10);
            wait_start();
            rd(OFS_GEAR, {30'h0, GEAR_DIV16});
            rd(OFS_STATUS, 33'h33);
            $display("test %0d done", i);
        end
        cmp(33'(exp_r.size() + exp_b.size()), 33'h0);
        end_of_test();
    end
endmodule // tb_reset_boot_sequencer
`default_nettype wire

// file: verilog/rbs_pkg.sv
// Constants, field layouts and state encoding for the reset and boot sequencer
package rbs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STAB_TIME_NS    = 1638400;
    // Least time: round up to whole cycles
    localparam int unsigned STAB_CYCLES_DEF = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W    = 18;
    localparam int unsigned RST_CNT_W       = 4;
    localparam logic [3:0]  RST_MIN_CLKS    = 4'hA;

    // ------------------------------------------------------------
    // Reset values and vector addresses
    // ------------------------------------------------------------
    localparam logic [23:0] VEC_ADDR_LO  = 24'hFFFF00;
    localparam logic [23:0] VEC_ADDR_MID = 24'hFFFF01;
    localparam logic [23:0] VEC_ADDR_HI  = 24'hFFFF02;
    localparam logic [31:0] SP_RESET     = 32'h0000_0000;
    localparam logic [2:0]  MASK_RESET   = 3'h7;
    localparam logic [1:0]  BANK_RESET   = 2'h0;
    localparam logic [2:0]  GEAR_DIV16   = 3'h4;
    localparam logic [1:0]  BOOT_WAITS   = 2'h1;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CTRL   = 12'h004;
    localparam logic [11:0] OFS_GEAR   = 12'h008;
    localparam logic [11:0] OFS_PC     = 12'h00C;
    localparam logic [11:0] OFS_SP     = 12'h010;
    localparam logic [11:0] OFS_SR     = 12'h014;
    localparam logic [11:0] OFS_STRAP  = 12'h018;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_ACC_BIT   = 2;
    localparam int unsigned STAT_CPURST    = 3;
    localparam int unsigned STAT_WDT_BIT   = 4;
    localparam int unsigned STAT_PORT_BIT  = 5;
    localparam int unsigned CTRL_PREL_BIT  = 0;
    localparam int unsigned SR_MASK_LSB    = 0;
    localparam int unsigned SR_BANK_LSB    = 4;
    localparam int unsigned STR_LO_BIT     = 0;
    localparam int unsigned STR_HI_BIT     = 1;
    localparam int unsigned STR_FA_BIT     = 2;
    localparam int unsigned STR_FB_BIT     = 3;
    localparam int unsigned STR_FAULT_BIT  = 4;
    localparam int unsigned STR_FFLT_BIT   = 5;
    localparam int unsigned STR_WAIT_LSB   = 8;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_SETTLE,
        ST_FETCH,
        ST_RUN
    } rbs_state_e;

endpackage

// file: verilog/rbs_reset_boot_sequencer.sv
// Reset and boot sequencer top: reset qualify, settle, vector load, APB
// ------------------------------------------------------------
// Functional notes
// - Reset sets clock gear to divide-by-16
// - Program counter loaded from three vector bytes
// - Stack pointer cleared to zero on reset
// - Interrupt mask level set to seven
// - Register bank pointer cleared to zero
// - Other CPU state untouched; run from vector
// - I/O defaults loaded, ports become inputs
// - Watchdog pin low in reset, high after
// - Internal reset held through doubler settle time
// - Bus width straps sampled at release
// ------------------------------------------------------------
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rbs_reset_boot_sequencer
    import rbs_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // External pins
    input  wire logic        reset_in_n,
    input  wire logic        bus_width_strap_lo,
    input  wire logic        bus_width_strap_hi,
    input  wire logic        factory_strap_a,
    input  wire logic        factory_strap_b,
    output logic             watchdog_out_pin,
    // Boot memory byte port
    output logic             vec_rd_req,
    output logic [23:0]      vec_addr,
    input  wire logic [7:0]  vec_rdata,
    input  wire logic        vec_rd_ack,
    // CPU core state
    output logic             cpu_reset,
    output logic             cpu_start,
    output logic [23:0]      program_counter,
    output logic [31:0]      system_stack_pointer,
    output logic [2:0]       interrupt_mask_level,
    output logic [1:0]       register_bank_pointer,
    // Clock, ports, bus
    output logic [2:0]       clock_gear,
    output logic             port_input_mode,
    output logic             io_regs_init,
    output logic             bus_16bit,
    output logic [1:0]       bus_wait_states,
    output logic             strap_fault,
    output logic             factory_fault,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rbs_state_e              state;
        logic [SETTLE_CNT_W-1:0] settle_cnt;
        logic                    strap_lo;
        logic                    strap_hi;
        logic                    strap_fa;
        logic                    strap_fb;
        logic                    strap_fault;
        logic                    factory_fault;
        logic [23:0]             pc;
        logic [31:0]             sp;
        logic [2:0]              mask;
        logic [1:0]              bank;
        logic [2:0]              gear;
        logic                    port_in;
        logic                    io_init;
        logic                    wdt;
        logic                    cpu_rst;
        logic                    cpu_start;
        logic                    fetch_start;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } rbs_top_s;

    rbs_top_s s_q;
    rbs_top_s s_d;

    rbs_seq_if seq ();

    localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(STAB_CYCLES - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    rbs_rst_filter u_filter (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .reset_in_n (reset_in_n),
        .seq        (seq.filt)
    );

    rbs_vec_fetch u_fetch (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .seq        (seq.fetch),
        .vec_rd_req (vec_rd_req),
        .vec_addr   (vec_addr),
        .vec_rdata  (vec_rdata),
        .vec_rd_ack (vec_rd_ack)
    );

    assign seq.fetch_start = s_q.fetch_start;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_ok(input logic [11:0] a);
        if (a == OFS_STATUS) begin
            addr_ok = 1'b1;
        end else if (a == OFS_CTRL) begin
            addr_ok = 1'b1;
        end else if (a == OFS_GEAR) begin
            addr_ok = 1'b1;
        end else if (a == OFS_PC) begin
            addr_ok = 1'b1;
        end else if (a == OFS_SP) begin
            addr_ok = 1'b1;
        end else if (a == OFS_SR) begin
            addr_ok = 1'b1;
        end else if (a == OFS_STRAP) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] a, input rbs_top_s q);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == OFS_STATUS) begin
            w[STAT_STATE_LSB +: 2] = q.state;
            w[STAT_ACC_BIT]        = seq.reset_accepted;
            w[STAT_CPURST]         = q.cpu_rst;
            w[STAT_WDT_BIT]        = q.wdt;
            w[STAT_PORT_BIT]       = q.port_in;
        end else if (a == OFS_CTRL) begin
            w[CTRL_PREL_BIT] = ~q.port_in;
        end else if (a == OFS_GEAR) begin
            w[2:0] = q.gear;
        end else if (a == OFS_PC) begin
            w[23:0] = q.pc;
        end else if (a == OFS_SP) begin
            w = q.sp;
        end else if (a == OFS_SR) begin
            w[SR_MASK_LSB +: 3] = q.mask;
            w[SR_BANK_LSB +: 2] = q.bank;
        end else if (a == OFS_STRAP) begin
            w[STR_LO_BIT]        = q.strap_lo;
            w[STR_HI_BIT]        = q.strap_hi;
            w[STR_FA_BIT]        = q.strap_fa;
            w[STR_FB_BIT]        = q.strap_fb;
            w[STR_FAULT_BIT]     = q.strap_fault;
            w[STR_FFLT_BIT]      = q.factory_fault;
            w[STR_WAIT_LSB +: 2] = BOOT_WAITS;
        end
        read_word = w;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic apb_setup;
    logic apb_wr;

    always_comb begin
        s_d             = s_q;
        s_d.cpu_start   = 1'b0;
        s_d.fetch_start = 1'b0;

        // APB: answer registered in the setup cycle, so every access
        // completes in its first access cycle with no wait states.
        apb_setup   = psel && !penable;
        apb_wr      = psel && penable && pwrite && s_q.pready;
        s_d.pready  = apb_setup;
        s_d.pslverr = apb_setup && !addr_ok(paddr);
        s_d.prdata  = (apb_setup && !pwrite) ? read_word(paddr, s_q) : 32'h0000_0000;

        if (apb_wr && pstrb[0]) begin
            if (paddr == OFS_GEAR) begin
                s_d.gear = pwdata[2:0];
            end else if (paddr == OFS_CTRL && pwdata[CTRL_PREL_BIT]) begin
                s_d.port_in = 1'b0;
            end
        end

        case (s_q.state)
            ST_HOLD: begin
                s_d.cpu_rst = 1'b1;
                s_d.sp      = SP_RESET;
                s_d.mask    = MASK_RESET;
                s_d.bank    = BANK_RESET;
                s_d.gear    = GEAR_DIV16;
                s_d.port_in = 1'b1;
                s_d.io_init = 1'b1;
                s_d.wdt     = 1'b0;
                // Stay until defaults are shown, else a short pulse never drops the pin
                if (!seq.reset_accepted && s_q.io_init) begin
                    // Straps caught on the release edge itself
                    s_d.strap_lo      = bus_width_strap_lo;
                    s_d.strap_hi      = bus_width_strap_hi;
                    s_d.strap_fault   = bus_width_strap_hi;
                    s_d.strap_fa      = factory_strap_a;
                    s_d.strap_fb      = factory_strap_b;
                    s_d.factory_fault = factory_strap_a | factory_strap_b;
                    s_d.wdt           = 1'b1;
                    s_d.io_init       = 1'b0;
                    s_d.settle_cnt    = '0;
                    s_d.state         = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (seq.reset_accepted) begin
                    s_d.state = ST_HOLD;
                end else if (s_q.settle_cnt == SETTLE_LAST) begin
                    // Doubler settled; vector fetch still under reset
                    s_d.fetch_start = 1'b1;
                    s_d.state       = ST_FETCH;
                end else begin
                    s_d.settle_cnt = s_q.settle_cnt + 1'b1;
                end
            end
            ST_FETCH: begin
                if (seq.reset_accepted) begin
                    s_d.state = ST_HOLD;
                end else if (seq.fetch_done) begin
                    s_d.pc        = seq.fetch_pc;
                    s_d.cpu_rst   = 1'b0;
                    s_d.cpu_start = 1'b1;
                    s_d.state     = ST_RUN;
                end
            end
            default: begin
                if (seq.reset_accepted) begin
                    s_d.state = ST_HOLD;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q         <= '0;
            s_q.state   <= ST_HOLD;
            s_q.sp      <= SP_RESET;
            s_q.mask    <= MASK_RESET;
            s_q.bank    <= BANK_RESET;
            s_q.gear    <= GEAR_DIV16;
            s_q.port_in <= 1'b1;
            s_q.io_init <= 1'b1;
            s_q.cpu_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Only these four CPU fields are touched; others stay with the core
    assign cpu_reset             = s_q.cpu_rst;
    assign cpu_start             = s_q.cpu_start;
    assign program_counter       = s_q.pc;
    assign system_stack_pointer  = s_q.sp;
    assign interrupt_mask_level  = s_q.mask;
    assign register_bank_pointer = s_q.bank;
    assign clock_gear            = s_q.gear;
    assign port_input_mode       = s_q.port_in;
    assign io_regs_init          = s_q.io_init;
    assign watchdog_out_pin      = s_q.wdt;
    assign bus_16bit             = s_q.strap_lo;
    assign bus_wait_states       = BOOT_WAITS;
    assign strap_fault           = s_q.strap_fault;
    assign factory_fault         = s_q.factory_fault;
    assign prdata                = s_q.prdata;
    assign pready                = s_q.pready;
    assign pslverr               = s_q.pslverr;

endmodule // rbs_reset_boot_sequencer
`default_nettype wire

// file: verilog/rbs_rst_filter.sv
// Synchroniser and low-length qualifier for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module rbs_rst_filter
    import rbs_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic reset_in_n,
    rbs_seq_if.filt   seq
);

    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic [RST_CNT_W-1:0] cnt;
        logic                 accepted;
    } rbs_filt_s;

    rbs_filt_s s_q;
    rbs_filt_s s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = reset_in_n;
        s_d.sync2 = s_q.sync1;
        if (s_q.sync2) begin
            // A single high sample restarts the count
            s_d.cnt      = '0;
            s_d.accepted = 1'b0;
        end else begin
            if (s_q.cnt != RST_MIN_CLKS) begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
            s_d.accepted = (s_q.cnt >= (RST_MIN_CLKS - 4'h1));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.sync1 <= 1'b1;
            s_q.sync2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign seq.reset_accepted = s_q.accepted;

endmodule // rbs_rst_filter
`default_nettype wire

// file: verilog/rbs_seq_if.sv
// Handshake bundle between the sequencer, reset filter and vector fetcher
`timescale 1ns/1ps
`default_nettype none
interface rbs_seq_if;
    logic        reset_accepted;
    logic        fetch_start;
    logic        fetch_done;
    logic [23:0] fetch_pc;

    modport filt  (output reset_accepted);
    modport fetch (input fetch_start, output fetch_done, output fetch_pc);
    modport ctrl  (input reset_accepted, input fetch_done, input fetch_pc, output fetch_start);
endinterface
`default_nettype wire

// file: verilog/rbs_vec_fetch.sv
// Three-byte reset vector fetch from the boot memory port
`timescale 1ns/1ps
`default_nettype none
module rbs_vec_fetch
    import rbs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    rbs_seq_if.fetch         seq,
    output logic             vec_rd_req,
    output logic [23:0]      vec_addr,
    input  wire logic [7:0]  vec_rdata,
    input  wire logic        vec_rd_ack
);

    typedef struct packed {
        logic        busy;
        logic [1:0]  idx;
        logic        req;
        logic [23:0] addr;
        logic [23:0] pc;
        logic        done;
    } rbs_fetch_s;

    rbs_fetch_s s_q;
    rbs_fetch_s s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (seq.fetch_start) begin
            // A new start aborts any fetch in flight
            s_d.busy = 1'b1;
            s_d.idx  = 2'h0;
            s_d.req  = 1'b1;
            s_d.addr = VEC_ADDR_LO;
        end else if (s_q.busy && s_q.req && vec_rd_ack) begin
            case (s_q.idx)
                2'h0: s_d.pc[7:0]   = vec_rdata;
                2'h1: s_d.pc[15:8]  = vec_rdata;
                default: s_d.pc[23:16] = vec_rdata;
            endcase
            if (s_q.idx == 2'h2) begin
                s_d.busy = 1'b0;
                s_d.req  = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.idx  = s_q.idx + 2'h1;
                s_d.addr = (s_q.idx == 2'h0) ? VEC_ADDR_MID : VEC_ADDR_HI;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign vec_rd_req     = s_q.req;
    assign vec_addr       = s_q.addr;
    assign seq.fetch_done = s_q.done;
    assign seq.fetch_pc   = s_q.pc;

endmodule // rbs_vec_fetch
`default_nettype wire
